//--- core/mrs_regs.svh
// Register offsets, reset values and timing figures of the reset supervisor.
// Included by the supervisor sources; holds definitions only.
`ifndef MRS_REGS_SVH
`define MRS_REGS_SVH

// Byte offsets on the register port
`define MRS_CTRL_OFS 8'h00
`define MRS_ADJ_OFS 8'h04
`define MRS_NOM0_OFS 8'h08
`define MRS_NOM5_OFS 8'h1C
`define MRS_STATUS_OFS 8'h20
`define MRS_COUNT_OFS 8'h24
`define MRS_CAUSE_OFS 8'h28

// Field positions
`define MRS_CTRL_FORCE_BIT 0
`define MRS_ST_MR_BIT 6
`define MRS_ST_TOL_BIT 7
`define MRS_ST_RST_BIT 8
`define MRS_ST_VALID_BIT 9
`define MRS_ST_PIN_BIT 10
`define MRS_ST_STATE_LSB 11
`define MRS_CA_MR_BIT 6
`define MRS_CA_FORCE_BIT 7
`define MRS_CA_INVALID_BIT 8

// Reset values
`define MRS_CTRL_RST 1'h0
`define MRS_ADJ_RST 6'h00
`define MRS_CAUSE_RST 9'h000
`define MRS_NOM0_RST 12'hCE4
`define MRS_NOM1_RST 12'h9C4
`define MRS_NOM2_RST 12'h5DC
`define MRS_NOM3_RST 12'h708
`define MRS_NOM4_RST 12'h4B0
`define MRS_NOM5_RST 12'h384

// Thresholds in millivolts, percent and permille
`define MRS_ADJ_MV 12'h1F4
`define MRS_VALID_MV 12'h3E8
`define MRS_TOL5_PCT 19'h5F
`define MRS_TOL10_PCT 19'h5A
`define MRS_PCT_DIV 19'h64
`define MRS_HYST_PERMILLE 14'h3
`define MRS_PERMILLE_DIV 14'h3E8

// Timing
`define MRS_CLK_KHZ 40000
`define MRS_CLK_NS 25
`define MRS_TIMEOUT_MS 140
`define MRS_GLITCH_NS 100
`define MRS_TIMEOUT_CYCLES (`MRS_TIMEOUT_MS * `MRS_CLK_KHZ)
`define MRS_GLITCH_CYCLES (`MRS_GLITCH_NS / `MRS_CLK_NS)

`endif

//--- core/mrs_pkg.sv
// Types shared by the reset supervisor sources.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package mrs_pkg;
   typedef logic [11:0] mrs_mv_t;
   typedef logic [5:0][11:0] mrs_levels_t;
   typedef logic [7:0] mrs_addr_t;
   typedef logic [31:0] mrs_word_t;
   typedef enum logic [1:0] {
      MRS_ST_HOLD = 2'b00,
      MRS_ST_TIMEOUT = 2'b01,
      MRS_ST_RUN = 2'b10
   } mrs_state_t;
endpackage

`default_nettype wire

//--- core/mrs_level_filter.sv
// Two-flop synchroniser followed by a stability filter for one pin.
// Assumes the pin is asynchronous to core_clk; the output moves only after
// the synchronised level has held for STABLE cycles.
`default_nettype none

module mrs_level_filter #(
   parameter int unsigned STABLE = 4,
   parameter logic RST_LEVEL = 1'b1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Pin and filtered level
   input wire logic pin,
   output logic level
);
   localparam int unsigned CW = $clog2(STABLE + 1);
   localparam logic [CW-1:0] LAST = CW'(STABLE - 1);

   logic sync1;
   logic sync2;
   logic [CW-1:0] count;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync1 <= RST_LEVEL;
         sync2 <= RST_LEVEL;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
      end
   end

   // Short pulses restart the count and never reach the output
   always_ff @(posedge core_clk) begin
      if (srst) begin
         count <= '0;
         level <= RST_LEVEL;
      end else if (sync2 == level) begin
         count <= '0;
      end else if (count == LAST) begin
         count <= '0;
         level <= sync2;
      end else begin
         count <= count + 1'b1;
      end
   end
endmodule

`default_nettype wire

//--- core/mrs_supervisor.sv
// Six-supply reset supervisor: digital threshold compare with hysteresis,
// manual reset input, tolerance select and the reset timeout.
// Assumes supply levels arrive in millivolts from converters on core_clk;
// the manual reset, tolerance and reset readback pins are asynchronous.
//
// Contract
// (RULE1) Any supply below its selected threshold drives reset low at once.
// (RULE2) After all supplies are good, reset stays low at least 140 ms.
// (RULE3) At power-up reset is low until supplies good and timeout elapsed.
// (RULE4) Each comparison has 0.3 percent hysteresis above the falling trip level.
// (RULE5) Reset stays low while any supply is bad and primary or secondary exceeds 1.0 V.
// (RULE6) Low manual reset request asserts reset.
// (RULE7) Reset holds while manual request low, then 140 ms more.
// (RULE8) Tolerance select low gives 5 percent, high gives 10 percent below nominal.
// (RULE9) The system must tie tolerance select to a defined level.
// (RULE10) Adjustable inputs compare against a fixed 0.5 V threshold; the code applies the tolerance to 0.5 V and trips at 475 or 450 mV.
// (RULE11) Unused monitor inputs must be held above their threshold.
// (RULE12) Manual request must be held 1 us; shorter glitches may be ignored.
// (RULE13) A cause during the timeout reasserts reset and restarts the full timeout.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`include "mrs_regs.svh"
`default_nettype none

module mrs_supervisor #(
   parameter int unsigned TIMEOUT_CYCLES = `MRS_TIMEOUT_CYCLES,
   parameter int unsigned GLITCH_CYCLES = `MRS_GLITCH_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Register port
   input wire mrs_pkg::mrs_addr_t reg_addr,
   input wire mrs_pkg::mrs_word_t reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output mrs_pkg::mrs_word_t reg_rdata,
   // Supply monitors, index 0 is the primary supply, 1 the secondary
   input wire mrs_pkg::mrs_levels_t supply_level,
   // Pins
   input wire logic manual_reset_request_n,
   input wire logic tolerance_select,
   input wire logic sys_reset_n_in,
   output logic sys_reset_n_out,
   output logic sys_reset_n_oe
);
   import mrs_pkg::*;

   localparam int unsigned CNT_W = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
   localparam mrs_levels_t NOM_RST = {`MRS_NOM5_RST, `MRS_NOM4_RST, `MRS_NOM3_RST,
                                      `MRS_NOM2_RST, `MRS_NOM1_RST, `MRS_NOM0_RST};

   // Falling trip level for a nominal level and the tolerance choice
   function automatic mrs_mv_t trip_of(input mrs_mv_t nom, input logic wide);
      logic [18:0] prod;
      prod = 19'(nom) * (wide ? `MRS_TOL10_PCT : `MRS_TOL5_PCT);
      return mrs_mv_t'(prod / `MRS_PCT_DIV);
   endfunction

   // Rising level: trip plus hysteresis, one bit wider so it cannot wrap
   function automatic logic [12:0] rise_of(input mrs_mv_t trip);
      logic [13:0] step;
      step = (14'(trip) * `MRS_HYST_PERMILLE) / `MRS_PERMILLE_DIV;
      return 13'(trip) + step[12:0];
   endfunction

   // Register index of a nominal-level offset
   function automatic logic [2:0] nom_index(input mrs_addr_t addr);
      mrs_addr_t rel;
      rel = addr - `MRS_NOM0_OFS;
      return rel[4:2];
   endfunction

   // Filtered pins
   logic mr_level_n;
   logic tol_level;
   logic pin_level_n;

   // Manual request: glitch filter keeps short pulses out
   mrs_level_filter #(
      .STABLE(GLITCH_CYCLES),
      .RST_LEVEL(1'b1)
   ) u_mr_filter (
      .core_clk(core_clk),
      .srst(srst),
      .pin(manual_reset_request_n),
      .level(mr_level_n)
   ); // RULE12

   // Tolerance select is strapped; a floating pin would wander between sets
   mrs_level_filter #(
      .STABLE(GLITCH_CYCLES),
      .RST_LEVEL(1'b0)
   ) u_tol_filter (
      .core_clk(core_clk),
      .srst(srst),
      .pin(tolerance_select),
      .level(tol_level)
   ); // RULE9

   // Readback of the shared reset wire
   mrs_level_filter #(
      .STABLE(1),
      .RST_LEVEL(1'b0)
   ) u_pin_sync (
      .core_clk(core_clk),
      .srst(srst),
      .pin(sys_reset_n_in),
      .level(pin_level_n)
   );

   // Registers
   logic ctrl_force;
   logic [5:0] adj_sel;
   mrs_levels_t nominal;
   logic [8:0] cause;
   logic [5:0] good;
   logic [CNT_W-1:0] count;
   mrs_state_t state;
   mrs_state_t next_state;

   // Decode
   wire ctrl_hit = reg_addr == `MRS_CTRL_OFS;
   wire adj_hit = reg_addr == `MRS_ADJ_OFS;
   wire nom_hit = (reg_addr >= `MRS_NOM0_OFS) && (reg_addr <= `MRS_NOM5_OFS) &&
                  (reg_addr[1:0] == 2'h0);
   wire status_hit = reg_addr == `MRS_STATUS_OFS;
   wire count_hit = reg_addr == `MRS_COUNT_OFS;
   wire cause_hit = reg_addr == `MRS_CAUSE_OFS;
   wire [2:0] nom_idx = nom_index(reg_addr);

   // Thresholds and comparison
   mrs_levels_t trip_lo;
   logic [5:0][12:0] trip_hi;
   logic [5:0] next_good;

   always_comb begin
      for (int i = 0; i < 6; i++) begin
         trip_lo[i] = trip_of(adj_sel[i] ? `MRS_ADJ_MV : nominal[i], tol_level); // RULE8 RULE10
         trip_hi[i] = rise_of(trip_lo[i]);
         if (good[i]) begin
            next_good[i] = supply_level[i] >= trip_lo[i]; // RULE1
         end else begin
            next_good[i] = {1'b0, supply_level[i]} >= trip_hi[i]; // RULE4
         end
      end
   end

   // Every input counts, so unused ones must sit above their threshold
   wire all_good = &good; // RULE11
   wire mr_active = ~mr_level_n;
   wire out_valid = (supply_level[0] > `MRS_VALID_MV) || (supply_level[1] > `MRS_VALID_MV);
   wire cause_any = ~all_good | mr_active | ctrl_force; // RULE6
   wire count_done = count == CNT_LAST;

   // Sticky cause capture; a new event beats a clear in the same cycle
   wire [8:0] cause_set = {~out_valid, ctrl_force, mr_active, ~good};
   wire [8:0] cause_clr = (reg_write && cause_hit) ? reg_wdata[8:0] : 9'h000;
   wire [8:0] next_cause = (cause & ~cause_clr) | cause_set;

   always_comb begin
      case (state)
         MRS_ST_HOLD: begin
            next_state = cause_any ? MRS_ST_HOLD : MRS_ST_TIMEOUT; // RULE5 RULE7
         end
         MRS_ST_TIMEOUT: begin
            if (cause_any) begin
               next_state = MRS_ST_HOLD; // RULE13
            end else if (count_done) begin
               next_state = MRS_ST_RUN; // RULE2
            end else begin
               next_state = MRS_ST_TIMEOUT;
            end
         end
         MRS_ST_RUN: begin
            next_state = cause_any ? MRS_ST_HOLD : MRS_ST_RUN; // RULE1
         end
         default: begin
            next_state = MRS_ST_HOLD;
         end
      endcase
   end

   wire next_reset_n = next_state == MRS_ST_RUN;

   // Read selection
   wire [31:0] status_word = {19'h00000, state, pin_level_n, out_valid, sys_reset_n_oe,
                              tol_level, mr_active, good};
   wire [31:0] read_word =
      ctrl_hit ? {31'h00000000, ctrl_force} :
      adj_hit ? {26'h0000000, adj_sel} :
      nom_hit ? {20'h00000, nominal[nom_idx]} :
      status_hit ? status_word :
      count_hit ? 32'(count) :
      cause_hit ? {23'h000000, cause} : 32'h00000000;

   // State and timeout counter; power-up starts in hold with all supplies bad
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= MRS_ST_HOLD; // RULE3
         count <= '0;
         good <= 6'h00;
      end else begin
         state <= next_state;
         good <= next_good;
         count <= (state == MRS_ST_TIMEOUT && !cause_any) ? count + 1'b1 : '0; // RULE13
      end
   end

   // Open-drain output: value is always low, the enable does the asserting
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sys_reset_n_out <= 1'b0;
         sys_reset_n_oe <= 1'b1; // RULE3
      end else begin
         sys_reset_n_out <= 1'b0;
         sys_reset_n_oe <= ~next_reset_n; // RULE1 RULE6
      end
   end

   // Software-written registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_force <= `MRS_CTRL_RST;
         adj_sel <= `MRS_ADJ_RST;
         nominal <= NOM_RST;
         cause <= `MRS_CAUSE_RST;
      end else begin
         cause <= next_cause;
         if (reg_write && ctrl_hit) begin
            ctrl_force <= reg_wdata[`MRS_CTRL_FORCE_BIT];
         end
         if (reg_write && adj_hit) begin
            adj_sel <= reg_wdata[5:0];
         end
         if (reg_write && nom_hit) begin
            nominal[nom_idx] <= reg_wdata[11:0];
         end
      end
   end

   // Read data stand for the one cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (srst) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= reg_read ? read_word : 32'h00000000;
      end
   end
endmodule

`default_nettype wire

//--- test/mrs_monitor.sv
// Port checker for the reset supervisor, bound to every instance.
// Assumes the primary supply keeps its reset nominal level of 3300 mV.
`default_nettype none
module mrs_monitor #(
   parameter int unsigned TIMEOUT_CYCLES = 20
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Register port
   input wire logic reg_read,
   input wire mrs_pkg::mrs_word_t reg_rdata,
   // Supplies and pins
   input wire mrs_pkg::mrs_levels_t supply_level,
   input wire logic manual_reset_request_n,
   input wire logic tolerance_select,
   input wire logic sys_reset_n_out,
   input wire logic sys_reset_n_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   import mrs_pkg::*;
   logic [31:0] quiet_cnt;
   logic [31:0] up_cnt;
   // Only the primary supply is watched, so the quiet count is an upper bound
   wire logic cause = !manual_reset_request_n || supply_level[0] < 12'hCE4;
   always_ff @(posedge core_clk) begin
      quiet_cnt <= (srst || cause) ? 32'h0 : quiet_cnt + 32'h1;
      up_cnt <= srst ? 32'h0 : up_cnt + 32'h1;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence s_mr_low; !manual_reset_request_n [*8]; endsequence
   sequence s_tol5_low; !tolerance_select [*8] ##0 supply_level[0] < 12'hC3F; endsequence
   property p_pin_low; sys_reset_n_out == 1'b0; endproperty
   a_pin_low: assert property (p_pin_low) else $error("reset pin not low");
   property p_powerup; $fell(srst) |-> sys_reset_n_oe; endproperty
   a_powerup: assert property (p_powerup) else $error("reset free at power-up");
   property p_bad; supply_level[0] < 12'hB9A |-> ##[1:3] sys_reset_n_oe; endproperty
   a_bad: assert property (p_bad) else $error("low supply without reset");
   property p_tol5; s_tol5_low |-> ##[1:3] sys_reset_n_oe; endproperty
   a_tol5: assert property (p_tol5) else $error("five percent trip missed");
   property p_mr; s_mr_low |-> ##[1:3] sys_reset_n_oe; endproperty
   a_mr: assert property (p_mr) else $error("manual request ignored");
   property p_mr_hold; s_mr_low |-> ##3 sys_reset_n_oe [*8]; endproperty
   a_mr_hold: assert property (p_mr_hold) else $error("manual reset not held");
   property p_timeout; $fell(sys_reset_n_oe) |-> quiet_cnt >= TIMEOUT_CYCLES; endproperty
   a_timeout: assert property (p_timeout) else $error("timeout too short");
   property p_up_min; $fell(sys_reset_n_oe) |-> up_cnt >= TIMEOUT_CYCLES; endproperty
   a_up_min: assert property (p_up_min) else $error("early power-up release");
   property p_rdata; !$past(reg_read) |-> reg_rdata == 32'h0; endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
endmodule

bind mrs_supervisor mrs_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mon (.core_clk(core_clk),
   .srst(srst), .reg_read(reg_read), .reg_rdata(reg_rdata), .supply_level(supply_level),
   .manual_reset_request_n(manual_reset_request_n), .tolerance_select(tolerance_select),
   .sys_reset_n_out(sys_reset_n_out), .sys_reset_n_oe(sys_reset_n_oe));
`default_nettype wire

//--- test/mrs_sys_model.sv
// System side of the reset wire: resolves the open-drain line.
// Assumes a pull-up, so a released line reads high, never the last value.
`default_nettype none
module mrs_sys_model (
   // Supervisor pin
   input wire logic sys_reset_n_out,
   input wire logic sys_reset_n_oe,
   // Resolved wire
   output logic sys_reset_n_in
);
   timeunit 1ns;
   timeprecision 100ps;
   assign sys_reset_n_in = sys_reset_n_oe ? sys_reset_n_out : 1'b1;
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the reset supervisor with a short timeout.
// Assumes the default nominal levels and a 40 MHz clock.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import mrs_pkg::*;
   localparam int unsigned TMO = 20;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   mrs_addr_t reg_addr = 8'h00;
   mrs_word_t reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   mrs_word_t reg_rdata;
   mrs_levels_t supply_level = {12'h384, 12'h4B0, 12'h708, 12'h5DC, 12'h9C4, 12'hCE4};
   logic manual_reset_request_n = 1'b1;
   logic tolerance_select = 1'b0;
   logic sys_reset_n_in;
   logic sys_reset_n_out;
   logic sys_reset_n_oe;
   int bad_count = 0;
   int n_tests = 0;
   int t;
   always #12.5 core_clk = ~core_clk;
   mrs_supervisor #(.TIMEOUT_CYCLES(TMO)) uut (.core_clk(core_clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .supply_level(supply_level),
      .manual_reset_request_n(manual_reset_request_n), .tolerance_select(tolerance_select),
      .sys_reset_n_in(sys_reset_n_in), .sys_reset_n_out(sys_reset_n_out),
      .sys_reset_n_oe(sys_reset_n_oe));
   mrs_sys_model sys (.sys_reset_n_out(sys_reset_n_out), .sys_reset_n_oe(sys_reset_n_oe),
      .sys_reset_n_in(sys_reset_n_in));
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input mrs_addr_t a, input mrs_word_t d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
      #1;
   endtask
   task automatic rd(input string what, input mrs_addr_t a, input mrs_word_t exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      chk(what, exp, reg_rdata);
   endtask
   // Waits for the reset enable to reach v, then checks the delay and the wire
   task automatic wait_oe(input logic v, input int min, input int lim);
      t = 0;
      while (sys_reset_n_oe !== v) begin
         if (t == lim) begin
            chk("reset wait", {31'h0, v}, {31'h0, sys_reset_n_oe});
            test_done();
         end
         cyc(1);
         t++;
      end
      chk("reset delay", 32'h1, {31'h0, t >= min});
      chk("reset wire", {31'h0, !v}, {31'h0, sys_reset_n_in});
   endtask
   initial begin
      cyc(12);
      srst <= 1'b0;
      wait_oe(1'b0, TMO, 60);
      rd("ctrl", 8'h00, 32'h0);
      rd("nom0", 8'h08, 32'hCE4);
      rd("nom5", 8'h1C, 32'h384);
      wr(8'h30, 32'hFFFF_FFFF);
      rd("unmapped", 8'h30, 32'h0);
      supply_level[2] <= 12'h590;
      wait_oe(1'b1, 0, 3);
      // One below the rising trip point: must stay bad
      supply_level[2] <= 12'h594;
      cyc(30);
      chk("hysteresis", 32'h1, {31'h0, sys_reset_n_oe});
      supply_level[2] <= 12'h595;
      wait_oe(1'b0, TMO, 60);
      tolerance_select <= 1'b1;
      cyc(10);
      supply_level[2] <= 12'h578;
      cyc(30);
      chk("ten percent", 32'h0, {31'h0, sys_reset_n_oe});
      tolerance_select <= 1'b0;
      wait_oe(1'b1, 0, 12);
      supply_level[2] <= 12'h5DC;
      wait_oe(1'b0, TMO, 60);
      supply_level[1] <= 12'h384;
      wait_oe(1'b1, 0, 3);
      supply_level[0] <= 12'h384;
      cyc(40);
      chk("both low", 32'h1, {31'h0, sys_reset_n_oe});
      supply_level[1:0] <= {12'h9C4, 12'hCE4};
      wait_oe(1'b0, TMO, 60);
      wr(8'h04, 32'h8);
      rd("adjust", 8'h04, 32'h8);
      supply_level[3] <= 12'h1DA;
      wait_oe(1'b1, 0, 3);
      supply_level[3] <= 12'h1E0;
      wait_oe(1'b0, TMO, 60);
      // Single-cycle dip lies under the glitch filter
      manual_reset_request_n <= 1'b0;
      cyc(1);
      manual_reset_request_n <= 1'b1;
      cyc(12);
      chk("glitch", 32'h0, {31'h0, sys_reset_n_oe});
      manual_reset_request_n <= 1'b0;
      wait_oe(1'b1, 0, 10);
      cyc(40);
      chk("manual held", 32'h1, {31'h0, sys_reset_n_oe});
      manual_reset_request_n <= 1'b1;
      cyc(15);
      chk("manual timeout", 32'h1, {31'h0, sys_reset_n_oe});
      supply_level[4] <= 12'h400;
      cyc(2);
      supply_level[4] <= 12'h4B0;
      wait_oe(1'b0, TMO, 60);
      // Let the wire readback settle through its synchroniser
      cyc(4);
      rd("status", 8'h20, 32'h163F);
      rd("count", 8'h24, 32'h0);
      rd("cause", 8'h28, 32'h17F);
      wr(8'h28, 32'h1FF);
      rd("cause clear", 8'h28, 32'h0);
      wr(8'h00, 32'h1);
      wait_oe(1'b1, 0, 3);
      rd("cause force", 8'h28, 32'h80);
      wr(8'h00, 32'h0);
      wait_oe(1'b0, TMO, 60);
      test_done();
   end
endmodule
`default_nettype wire
